// File: design/clock_frequency_checker.sv
// Purpose: checks a monitored clock count against thresholds per reference window
// Assumes: clocks arrive as synchronous levels, far slower than i_core_clk
// Notes: config writes are plain strobes; ignored while checking is enabled
`timescale 1ns/100ps
// Overview of operation
// - window count writes ignored while enabled
// - high threshold writes ignored while enabled
// - low threshold writes ignored while enabled
// - interrupt enable writes ignored while enabled
// - status holds running, above, below flags
// - above flag when count exceeds high
// - below flag when count under low
// - separate sync interrupt enables per event
// - separate async interrupt enables per event
// - window length from programmed reference count
// - programmable high threshold count held
// - programmable low threshold count held
// - above and below status flags cleared by written mask
// - checking starts when enable bit set
module clock_frequency_checker
	import cfc_pkg::*;
#(
	parameter int CNT_W = CFC_CNT_W
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_ref_clk,
	input wire logic i_mon_clk,
	input wire logic i_check_enable,
	input wire logic i_window_count_wr,
	input wire logic [CNT_W-1:0] i_window_count_data,
	input wire logic i_high_threshold_wr,
	input wire logic [CNT_W-1:0] i_high_threshold_data,
	input wire logic i_low_threshold_wr,
	input wire logic [CNT_W-1:0] i_low_threshold_data,
	input wire logic i_interrupt_enable_wr,
	input wire logic [CFC_IE_W-1:0] i_interrupt_enable_data,
	input wire logic i_status_clear_wr,
	input wire logic [CFC_SR_W-1:0] i_status_clear_mask,
	output logic [CNT_W-1:0] o_window_count_reg,
	output logic [CNT_W-1:0] o_high_threshold_reg,
	output logic [CNT_W-1:0] o_low_threshold_reg,
	output logic [CFC_IE_W-1:0] o_interrupt_enable_reg,
	output logic [CFC_SR_W-1:0] o_status_reg,
	output logic [CNT_W-1:0] o_mon_count,
	output logic o_sync_irq,
	output logic o_async_irq
);
	initial begin
		if (CNT_W < 2 || CNT_W > 32) begin
			$error("CNT_W must be 2..32");
		end
	end

	typedef struct packed {
		cfc_state_e state;
		logic [CNT_W-1:0] window_count_reg;
		logic [CNT_W-1:0] high_threshold_reg;
		logic [CNT_W-1:0] low_threshold_reg;
		logic [CFC_IE_W-1:0] interrupt_enable_reg;
		logic check_running_flag;
		logic above_high_flag;
		logic below_low_flag;
		logic [CNT_W-1:0] ref_cnt;
		logic [CNT_W-1:0] mon_cnt;
		logic [CNT_W-1:0] mon_result;
		logic sync_irq;
		logic async_irq;
	} cfc_core_s;

	cfc_core_s st;
	cfc_core_s next_st;
	cfc_edge_if ref_edge ();
	cfc_edge_if mon_edge ();
	logic set_high;
	logic set_low;
	logic clr_high;
	logic clr_low;

	cfc_edge_det u_ref_edge (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_level(i_ref_clk),
		.edge_port(ref_edge.src)
	);
	cfc_edge_det u_mon_edge (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_level(i_mon_clk),
		.edge_port(mon_edge.src)
	);

	// saturating increment so a dead reference cannot wrap the monitored count
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
	endfunction

	always_comb begin
		next_st = st;
		set_high = 1'b0;
		set_low = 1'b0;
		// configuration frozen while enabled
		if (!i_check_enable && i_window_count_wr) begin
			next_st.window_count_reg = i_window_count_data;
		end
		if (!i_check_enable && i_high_threshold_wr) begin
			next_st.high_threshold_reg = i_high_threshold_data;
		end
		if (!i_check_enable && i_low_threshold_wr) begin
			next_st.low_threshold_reg = i_low_threshold_data;
		end
		if (!i_check_enable && i_interrupt_enable_wr) begin
			next_st.interrupt_enable_reg = i_interrupt_enable_data;
		end
		case (st.state)
			CFC_IDLE: begin
				next_st.check_running_flag = 1'b0;
				if (i_check_enable) begin
					next_st.state = CFC_COUNT;
					next_st.check_running_flag = 1'b1;
					next_st.ref_cnt = '0;
					next_st.mon_cnt = '0;
				end
			end
			CFC_COUNT: begin
				if (!i_check_enable) begin
					// stop honoured here, where running reads 1
					next_st.state = CFC_IDLE;
					next_st.check_running_flag = 1'b0;
				end else begin
					if (mon_edge.pulse) begin
						next_st.mon_cnt = sat_inc(st.mon_cnt);
					end
					if (ref_edge.pulse) begin
						next_st.ref_cnt = sat_inc(st.ref_cnt);
						if (sat_inc(st.ref_cnt) >= st.window_count_reg) begin
							next_st.state = CFC_JUDGE;
						end
					end
				end
			end
			CFC_JUDGE: begin
				// one cycle spent judging; monitored edges here are dropped
				next_st.mon_result = st.mon_cnt;
				set_high = st.mon_cnt > st.high_threshold_reg;
				set_low = st.mon_cnt < st.low_threshold_reg;
				next_st.ref_cnt = '0;
				next_st.mon_cnt = '0;
				next_st.state = i_check_enable ? CFC_COUNT : CFC_IDLE;
				next_st.check_running_flag = i_check_enable;
			end
			default: begin
				next_st.state = CFC_IDLE;
			end
		endcase
		clr_high = i_status_clear_wr && i_status_clear_mask[CFC_SR_HIGH];
		clr_low = i_status_clear_wr && i_status_clear_mask[CFC_SR_LOW];
		// set wins over clear in the same cycle
		next_st.above_high_flag = set_high | (st.above_high_flag & ~clr_high);
		next_st.below_low_flag = set_low | (st.below_low_flag & ~clr_low);
		// next enables too, so an enable write and its irq land together
		next_st.sync_irq = (next_st.above_high_flag
			& next_st.interrupt_enable_reg[CFC_IE_SYNC_HIGH])
			| (next_st.below_low_flag
			& next_st.interrupt_enable_reg[CFC_IE_SYNC_LOW]);
		next_st.async_irq = (next_st.above_high_flag
			& next_st.interrupt_enable_reg[CFC_IE_ASYNC_HIGH])
			| (next_st.below_low_flag
			& next_st.interrupt_enable_reg[CFC_IE_ASYNC_LOW]);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
			st.state <= CFC_IDLE;
			st.window_count_reg <= CFC_WINDOW_RST[CNT_W-1:0];
			st.high_threshold_reg <= CFC_HIGH_RST[CNT_W-1:0];
			st.low_threshold_reg <= CFC_LOW_RST[CNT_W-1:0];
			st.interrupt_enable_reg <= CFC_IE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_window_count_reg = st.window_count_reg;
	assign o_high_threshold_reg = st.high_threshold_reg;
	assign o_low_threshold_reg = st.low_threshold_reg;
	assign o_interrupt_enable_reg = st.interrupt_enable_reg;
	assign o_status_reg = {st.below_low_flag, st.above_high_flag, st.check_running_flag};
	assign o_mon_count = st.mon_result;
	assign o_sync_irq = st.sync_irq;
	assign o_async_irq = st.async_irq;
endmodule // clock_frequency_checker

// File: design/cfc_pkg.sv
// Purpose: constants and types shared by the clock frequency checker
// Assumes: one core clock, monitored and reference clocks sampled as inputs
// Notes: all widths and reset values live here
package cfc_pkg;
	localparam int CFC_CNT_W = 32;
	localparam logic [31:0] CFC_WINDOW_RST = 32'hFFFFFFFF;
	localparam logic [31:0] CFC_HIGH_RST = 32'hFFFFFFFF;
	localparam logic [31:0] CFC_LOW_RST = 32'h00000000;
	// interrupt enable layout: sync low, sync high, async low, async high
	localparam int CFC_IE_W = 4;
	localparam int CFC_IE_SYNC_LOW = 0;
	localparam int CFC_IE_SYNC_HIGH = 1;
	localparam int CFC_IE_ASYNC_LOW = 2;
	localparam int CFC_IE_ASYNC_HIGH = 3;
	localparam logic [3:0] CFC_IE_RST = 4'hC;
	// status layout
	localparam int CFC_SR_W = 3;
	localparam int CFC_SR_RUN = 0;
	localparam int CFC_SR_HIGH = 1;
	localparam int CFC_SR_LOW = 2;
	typedef enum logic [1:0] {CFC_IDLE, CFC_COUNT, CFC_JUDGE} cfc_state_e;
endpackage

// File: design/cfc_edge_if.sv
// Purpose: carries edge pulses from the clock samplers to the core
// Assumes: one core clock domain
// Notes: pulse is one core cycle wide per rising edge seen
`timescale 1ns/100ps
interface cfc_edge_if;
	logic pulse;
	modport src (output pulse);
	modport dst (input pulse);
endinterface

// File: design/cfc_edge_det.sv
// Purpose: rising edge detector on a sampled clock input
// Assumes: input is slower than half the core clock
// Notes: one cycle of latency
`timescale 1ns/100ps
module cfc_edge_det (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_level,
	cfc_edge_if.src edge_port
);
	typedef struct packed {
		logic last;
		logic pulse;
	} cfc_edge_s;
	cfc_edge_s st;
	cfc_edge_s next_st;
	always_comb begin
		next_st = st;
		next_st.last = i_level;
		next_st.pulse = i_level & ~st.last;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign edge_port.pulse = st.pulse;
endmodule // cfc_edge_det

// File: verif/cfc_properties.sv
// Purpose: port-level properties of the clock frequency checker
// Assumes: one clock, async active-low reset
// Notes: bound to the top module
`timescale 1ns/100ps
module cfc_properties
	import cfc_pkg::*;
#(
	parameter int CNT_W = CFC_CNT_W
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_check_enable,
	input wire logic i_window_count_wr,
	input wire logic [CNT_W-1:0] i_window_count_data,
	input wire logic i_high_threshold_wr,
	input wire logic i_low_threshold_wr,
	input wire logic i_interrupt_enable_wr,
	input wire logic i_status_clear_wr,
	input wire logic [CFC_SR_W-1:0] i_status_clear_mask,
	input wire logic [CNT_W-1:0] o_window_count_reg,
	input wire logic [CNT_W-1:0] o_high_threshold_reg,
	input wire logic [CNT_W-1:0] o_low_threshold_reg,
	input wire logic [CFC_IE_W-1:0] o_interrupt_enable_reg,
	input wire logic [CFC_SR_W-1:0] o_status_reg,
	input wire logic o_sync_irq,
	input wire logic o_async_irq
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	a_window_lock:
	assert property (i_check_enable && i_window_count_wr |=> $stable(o_window_count_reg))
		else $error("window count moved");
	a_high_lock:
	assert property (i_check_enable && i_high_threshold_wr |=> $stable(o_high_threshold_reg))
		else $error("high threshold moved");
	a_low_lock:
	assert property (i_check_enable && i_low_threshold_wr |=> $stable(o_low_threshold_reg))
		else $error("low threshold moved");
	a_ie_lock:
	assert property (i_check_enable && i_interrupt_enable_wr |=> $stable(o_interrupt_enable_reg))
		else $error("interrupt enable moved");
	a_window_write:
	assert property (!i_check_enable && i_window_count_wr
		|=> o_window_count_reg == $past(i_window_count_data)) else $error("window write lost");
	a_flag_sticky:
	assert property (o_status_reg[1] && !(i_status_clear_wr && i_status_clear_mask[1])
		|=> o_status_reg[1]) else $error("above flag dropped");
	a_flag_clear:
	assert property (i_status_clear_wr && i_status_clear_mask[2] && !o_status_reg[0]
		|=> !o_status_reg[2]) else $error("below flag kept");
	a_sync_map:
	assert property (o_sync_irq == (o_interrupt_enable_reg[0] && o_status_reg[2]
		|| o_interrupt_enable_reg[1] && o_status_reg[1])) else $error("sync irq wrong");
	a_async_map:
	assert property (o_async_irq == (o_interrupt_enable_reg[2] && o_status_reg[2]
		|| o_interrupt_enable_reg[3] && o_status_reg[1])) else $error("async irq wrong");
endmodule // cfc_properties

// File: verif/tb.sv
// Purpose: self-checking bench for the clock frequency checker
// Assumes: ref and mon clocks made here as slow levels
// Notes: count model allows a short first window
`timescale 1ns/100ps
module tb;
	import cfc_pkg::*;
	logic clk = 0, rst_b = 0, refc = 0, mon = 0, en = 0, si, ai;
	logic [4:0] wr = 0;
	logic [31:0] d = 0, wc, ht, lt, mc, m [4], r [4];
	logic [3:0] ie;
	logic [2:0] sr;
	int errors = 0, tests_run = 0, h = 2, rc = 0, mk = 0, n;
	always #10 clk = ~clk;
	// ref half period 4 cycles keeps it well under core/2
	always @(posedge clk) begin
		rc <= rc == 3 ? 0 : rc + 1;
		refc <= rc == 3 ? ~refc : refc;
		mk <= mk >= h - 1 ? 0 : mk + 1;
		mon <= mk >= h - 1 ? ~mon : mon;
	end
	always_comb r = '{wc, ht, lt, {28'h0, ie}};
	clock_frequency_checker uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_ref_clk(refc),
		.i_mon_clk(mon), .i_check_enable(en), .i_window_count_wr(wr[0]),
		.i_window_count_data(d), .i_high_threshold_wr(wr[1]), .i_high_threshold_data(d),
		.i_low_threshold_wr(wr[2]), .i_low_threshold_data(d), .i_interrupt_enable_wr(wr[3]),
		.i_interrupt_enable_data(d[3:0]), .i_status_clear_wr(wr[4]),
		.i_status_clear_mask(d[2:0]), .o_window_count_reg(wc), .o_high_threshold_reg(ht),
		.o_low_threshold_reg(lt), .o_interrupt_enable_reg(ie), .o_status_reg(sr),
		.o_mon_count(mc), .o_sync_irq(si), .o_async_irq(ai));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input int k, input logic [31:0] v);
		@(posedge clk);
		wr <= 5'h01 << k;
		d <= v;
		@(posedge clk);
		wr <= 5'h00;
		#1;
	endtask
	task automatic print_verdict;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'hD57F9F64));
		m = '{CFC_WINDOW_RST, CFC_HIGH_RST, CFC_LOW_RST, {28'h0, CFC_IE_RST}};
		repeat (3) @(posedge clk);
		rst_b <= 1;
		#1;
		for (int k = 0; k < 4; k++) chk(r[k], m[k]);
		chk(sr, 0);
		$display("reset test done");
		for (int c = 0; c < 2; c++) begin
			h = $urandom_range(3, 2);
			n = 24 / h;
			// six ref cycles of eight core cycles each
			m = '{32'h6, c ? 32'hFFFFFFFF : 32'(n - 5), c ? 32'(n + 3) : 0, $urandom & 32'hF};
			// short window keeps the run brief at the cost of accuracy
			for (int k = 0; k < 4; k++) put(k, m[k]);
			for (int k = 0; k < 4; k++) chk(r[k], m[k]);
			@(posedge clk) en <= 1;
			for (int k = 0; k < 4; k++) put(k, $urandom);
			for (int t = 0; t < 400 && sr[2:1] == 0; t++) @(posedge clk);
			#1;
			for (int k = 0; k < 4; k++) chk(r[k], m[k]);
			chk(sr, c ? 3'h5 : 3'h3);
			chk(mc inside {[n - 3 : n + 1]}, 1);
			chk(si, c ? m[3][0] : m[3][1]);
			chk(ai, c ? m[3][2] : m[3][3]);
			chk(sr[0], 1);
			@(posedge clk) en <= 0;
			repeat (2) @(posedge clk);
			#1;
			chk(sr, c ? 3'h4 : 3'h2);
			put(4, 32'h2 << c);
			chk({sr, si, ai}, 0);
			$display("case %0d done", c);
		end
		print_verdict();
	end
	// whole run is under two hundred cycles
	initial begin
		#(20 * 5000);
		errors++;
		print_verdict();
	end
endmodule // tb
bind clock_frequency_checker cfc_properties #(.CNT_W(CNT_W)) u_props (.*);
